// *** core/predriver_regs.vh ***
/*
  Constants for the pre-driver logic interface: frame length, command codes,
  fault mask layout and link timing.
  Assumes inclusion by bare name from core design files.
*/
`ifndef PREDRIVER_REGS_VH
`define PREDRIVER_REGS_VH

// ----------------------------------------------------------------------------
// Serial frame
// ----------------------------------------------------------------------------
`define FRAME_BITS        8
`define BIT_CNT_W         4
`define CMD_W             8

// ----------------------------------------------------------------------------
// Commands (upper three bits select, lower four carry data)
// ----------------------------------------------------------------------------
`define CMD_SEL_MSB       7
`define CMD_SEL_LSB       5
`define CMD_CLEAR_INT     3'h0
`define CMD_WRITE_FAULT_MASK_REG_0   3'h1
`define CMD_WRITE_FAULT_MASK_REG_1   3'h2
`define CMD_READ_STATUS   3'h3

// ----------------------------------------------------------------------------
// Faults and masks
// ----------------------------------------------------------------------------
`define FAULT_W           8
`define MASK_FIELD_W      4
`define FAULT_MASK_REG_0_RESET       4'h0
`define FAULT_MASK_REG_1_RESET       4'h0

// ----------------------------------------------------------------------------
// Link timing
// ----------------------------------------------------------------------------
`define SCLK_MAX_KHZ      5000
`define SCLK_TYP_KHZ      3000
`define CLK_SYS_KHZ       250000
`define SCLK_MIN_CYCLES   (`CLK_SYS_KHZ / `SCLK_MAX_KHZ)

`endif

// *** core/pin_sync.v ***
/*
  Two-stage synchroniser for a bundle of pin inputs.
  Assumes clk_sys is free running; ce freezes the stages.
*/
`timescale 1ns/1ps
module pin_sync #(
  parameter WIDTH = 1
) (
  // Clock and control
  input  wire             clk_sys,
  input  wire             srst,
  input  wire             ce,
  // Data
  input  wire [WIDTH-1:0] async_in,
  input  wire [WIDTH-1:0] reset_val,
  output reg  [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] stage1;

  // Reset value is a constant at every instance, so the reset stays constant.
  always @(posedge clk_sys) begin
    if (srst) begin
      stage1   <= reset_val;
      sync_out <= reset_val;
    end else if (ce) begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule // pin_sync

// *** core/predriver_logic.v ***
/*
  Logic-level interface of a three-phase FET pre-driver: SPI slave port,
  phase command decode, enable gating, interrupt and over-current flag.
  Assumes all pin inputs are asynchronous to clk_sys and that the serial
  clock is well below a quarter of clk_sys.
  Each serial clock level must last at least two clk_sys cycles, or an
  edge is lost in the synchronisers and the frame slips by one bit.
*/
// Behaviour
// RULE1: phase B low command active high
// RULE2: interrupt latches high until clear command
// RULE3: two mask registers suppress fault interrupts
// RULE4: active-low select frames every transfer
// RULE5: input sampled on falling clock, MSB first
// RULE6: host keeps serial clock at most 5 MHz; spi_host in the bench runs it at clk_sys/8, 31.25 MHz
// RULE7: data out high-impedance unless selected
// RULE8: data out bit changes on rising clock
// RULE9: host captures data out on falling clock
// RULE10: phase C low command active high
// RULE11: phase C high command active low
// RULE12: over-current flag follows condition
// RULE13: phase A and B high commands active low
// RULE14: phase A low command active high
// RULE15: both enables high or gates forced off
// RULE16: ignore clock unselected, restart each frame
`timescale 1ns/1ps
`include "predriver_regs.vh"
module predriver_logic (
  // Clock and control
  input  wire                 clk_sys,
  input  wire                 srst,
  input  wire                 ce,
  // Serial port
  input  wire                 spi_cs_n,
  input  wire                 spi_sclk,
  input  wire                 spi_sdi,
  output reg                  spi_sdo,
  output wire                 spi_sdo_oe,
  // Phase commands
  input  wire                 phase_a_high_cmd_n,
  input  wire                 phase_a_low_cmd,
  input  wire                 phase_b_high_cmd_n,
  input  wire                 phase_b_low_cmd,
  input  wire                 phase_c_high_cmd_n,
  input  wire                 phase_c_low_cmd,
  input  wire                 drive_enable_a,
  input  wire                 drive_enable_b,
  // Gate requests, active high
  output reg  [2:0]           gate_high_on,
  output reg  [2:0]           gate_low_on,
  // Faults and flags
  input  wire [`FAULT_W-1:0]  fault_in,
  input  wire                 overcurrent_in,
  output reg                  interrupt_out,
  output reg                  overcurrent_flag_out
);

  // --------------------------------------------------------------------------
  // Input synchronisers
  // --------------------------------------------------------------------------
  localparam NSYNC = 12 + `FAULT_W;
  wire [NSYNC-1:0] sync_q;
  // Pulls are modelled in the reset values: select and high commands idle high.
  pin_sync #(.WIDTH(NSYNC)) u_sync (
    .clk_sys   (clk_sys),
    .srst      (srst),
    .ce        (ce),
    .async_in  ({fault_in, overcurrent_in, drive_enable_b, drive_enable_a,
                 phase_c_low_cmd, phase_c_high_cmd_n, phase_b_low_cmd,
                 phase_b_high_cmd_n, phase_a_low_cmd, phase_a_high_cmd_n,
                 spi_sdi, spi_sclk, spi_cs_n}),
    .reset_val ({{`FAULT_W{1'b0}}, 4'h0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0,
                 1'b0, 1'b1}),
    .sync_out  (sync_q)
  );

  wire                cs_n_s = sync_q[0];
  wire                sclk_s = sync_q[1];
  wire                sdi_s  = sync_q[2];
  wire [5:0]          cmd_s  = sync_q[8:3];
  wire                en_a_s = sync_q[9];
  wire                en_b_s = sync_q[10];
  wire                oc_s   = sync_q[11];
  wire [`FAULT_W-1:0] flt_s  = sync_q[NSYNC-1:12];

  // --------------------------------------------------------------------------
  // Edge detection on synchronised pins
  // --------------------------------------------------------------------------
  reg sclk_d;
  reg cs_n_d;
  always @(posedge clk_sys) begin
    if (srst) begin
      sclk_d <= 1'b0;
      cs_n_d <= 1'b1;
    end else if (ce) begin
      sclk_d <= sclk_s;
      cs_n_d <= cs_n_s;
    end
  end

  wire selected  = ~cs_n_s;
  wire sclk_rise = selected & sclk_s & ~sclk_d;  // RULE16
  wire sclk_fall = selected & ~sclk_s & sclk_d;  // RULE16
  wire frame_beg = cs_n_d & ~cs_n_s;             // RULE4

  // --------------------------------------------------------------------------
  // Serial shift engine
  // --------------------------------------------------------------------------
  reg [`BIT_CNT_W-1:0] bit_cnt;
  reg [`CMD_W-1:0]     rx_shift;
  reg [`CMD_W-1:0]     tx_shift;
  reg                  cmd_valid;
  reg [`CMD_W-1:0]     cmd_word;
  reg [`MASK_FIELD_W-1:0] fault_mask_reg_0;
  reg [`MASK_FIELD_W-1:0] fault_mask_reg_1;
  reg [`FAULT_W-1:0]   fault_latch;

  wire [`CMD_W-1:0] next_rx = {rx_shift[`CMD_W-2:0], sdi_s};
  wire [`FAULT_W-1:0] mask_all = {fault_mask_reg_1, fault_mask_reg_0};

  // Status is loaded at frame start so the host sees a stable snapshot.
  // Data out is parked low while deselected, so once driven it moves only
  // after a serial clock rise.
  always @(posedge clk_sys) begin
    if (srst) begin
      bit_cnt   <= {`BIT_CNT_W{1'b0}};
      rx_shift  <= {`CMD_W{1'b0}};
      tx_shift  <= {`CMD_W{1'b0}};
      spi_sdo   <= 1'b0;
      cmd_valid <= 1'b0;
      cmd_word  <= {`CMD_W{1'b0}};
    end else if (ce) begin
      cmd_valid <= 1'b0;
      if (!selected) begin
        bit_cnt  <= {`BIT_CNT_W{1'b0}};                // RULE16
        spi_sdo  <= 1'b0;                              // RULE8
      end else if (frame_beg) begin
        bit_cnt  <= {`BIT_CNT_W{1'b0}};                // RULE16
        tx_shift <= fault_latch;
      end else if (sclk_rise) begin
        spi_sdo  <= tx_shift[`CMD_W-1];                // RULE8
        tx_shift <= {tx_shift[`CMD_W-2:0], 1'b0};
      end else if (sclk_fall) begin
        rx_shift <= next_rx;                           // RULE5
        if (bit_cnt == `FRAME_BITS - 1) begin
          bit_cnt   <= {`BIT_CNT_W{1'b0}};
          cmd_word  <= next_rx;
          cmd_valid <= 1'b1;
        end else begin
          bit_cnt <= bit_cnt + 4'h1;
        end
      end
    end
  end

  assign spi_sdo_oe = selected;  // RULE7

  // --------------------------------------------------------------------------
  // Command decode
  // --------------------------------------------------------------------------
  // One decoder serves the clear and both mask-write commands, so no code is compared twice.
  function cmd_hit;
    input [`CMD_W-1:0] word;
    input              valid;
    input [2:0]        code;
    begin
      cmd_hit = valid & (word[`CMD_SEL_MSB:`CMD_SEL_LSB] == code);
    end
  endfunction

  // --------------------------------------------------------------------------
  // Command execution, masks and interrupt
  // --------------------------------------------------------------------------
  wire       clear_cmd = cmd_hit(cmd_word, cmd_valid, `CMD_CLEAR_INT);  // RULE2
  wire       wr_fault_mask_reg_0  = cmd_hit(cmd_word, cmd_valid, `CMD_WRITE_FAULT_MASK_REG_0);
  wire       wr_fault_mask_reg_1  = cmd_hit(cmd_word, cmd_valid, `CMD_WRITE_FAULT_MASK_REG_1);
  wire [`FAULT_W-1:0] unmasked = flt_s & ~mask_all;  // RULE3

  // A fault arriving with the clear command wins, so no event is lost.
  always @(posedge clk_sys) begin
    if (srst) begin
      fault_mask_reg_0 <= `FAULT_MASK_REG_0_RESET;
      fault_mask_reg_1 <= `FAULT_MASK_REG_1_RESET;
      fault_latch      <= {`FAULT_W{1'b0}};
      interrupt_out    <= 1'b0;
    end else if (ce) begin
      if (wr_fault_mask_reg_0)
        fault_mask_reg_0 <= cmd_word[`MASK_FIELD_W-1:0];  // RULE3
      if (wr_fault_mask_reg_1)
        fault_mask_reg_1 <= cmd_word[`MASK_FIELD_W-1:0];  // RULE3
      fault_latch <= (clear_cmd ? {`FAULT_W{1'b0}} : fault_latch) | flt_s;
      if (|unmasked)
        interrupt_out <= 1'b1;                            // RULE2
      else if (clear_cmd)
        interrupt_out <= 1'b0;                            // RULE2
    end
  end

  // --------------------------------------------------------------------------
  // Phase commands and enable gating
  // --------------------------------------------------------------------------
  // Enables are asynchronous at the pin; from pin to gate request they cost three clocks of latency.
  // Gate requests follow the command levels; no dead time is inserted here.
  wire drive_ok = en_a_s & en_b_s;  // RULE15
  always @(posedge clk_sys) begin
    if (srst) begin
      gate_high_on         <= 3'h0;
      gate_low_on          <= 3'h0;
      overcurrent_flag_out <= 1'b0;
    end else if (ce) begin
      gate_high_on[0] <= drive_ok & ~cmd_s[0];  // RULE13
      gate_low_on[0]  <= drive_ok &  cmd_s[1];  // RULE14
      gate_high_on[1] <= drive_ok & ~cmd_s[2];  // RULE13
      gate_low_on[1]  <= drive_ok &  cmd_s[3];  // RULE1
      gate_high_on[2] <= drive_ok & ~cmd_s[4];  // RULE11
      gate_low_on[2]  <= drive_ok &  cmd_s[5];  // RULE10
      overcurrent_flag_out <= oc_s;             // RULE12
    end
  end

endmodule // predriver_logic

// *** dv/predriver_logic_chk.sv ***
/* Port assertions for predriver_logic.
   Assumes ce is held high by the bench. */
`timescale 1ns/1ps
module predriver_logic_chk (
  input wire       clk_sys,
  input wire       srst,
  input wire       spi_cs_n,
  input wire       spi_sclk,
  input wire       spi_sdo,
  input wire       spi_sdo_oe,
  input wire       drive_enable_a,
  input wire       drive_enable_b,
  input wire       phase_a_low_cmd,
  input wire [2:0] gate_high_on,
  input wire [2:0] gate_low_on,
  input wire       overcurrent_in,
  input wire       overcurrent_flag_out,
  input wire       interrupt_out
);
  reg [4:0] sel_age;
  reg [3:0] rise_age;
  reg       sclk_d;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  // Ages saturate so a long idle spell never wraps into a false match.
  always @(posedge clk_sys) begin
    sclk_d <= spi_sclk;
    sel_age <= srst ? 5'h1f : !spi_cs_n ? 5'h00 : sel_age + {4'h0, sel_age != 5'h1f};
    rise_age <= srst ? 4'hf : (spi_sclk && !sclk_d) ? 4'h0 : rise_age + {3'h0, rise_age != 4'hf};
  end
  sequence s_cs_idle; spi_cs_n [*3]; endsequence
  sequence s_cs_sel; !spi_cs_n [*3]; endsequence
  a_oe_idle: assert property (s_cs_idle |-> !spi_sdo_oe)
    else $error("data out driven while deselected");
  a_oe_sel: assert property (s_cs_sel |-> spi_sdo_oe)
    else $error("data out not driven while selected");
  a_ovc_high: assert property (overcurrent_in [*5] |-> overcurrent_flag_out)
    else $error("over-current flag missing");
  a_ovc_low: assert property (!overcurrent_in [*5] |-> !overcurrent_flag_out)
    else $error("over-current flag stuck");
  a_gate_off: assert property (!(drive_enable_a && drive_enable_b) [*5]
    |-> gate_high_on == 3'h0 && gate_low_on == 3'h0) else $error("gate on while disabled");
  a_low_a_on: assert property ((drive_enable_a && drive_enable_b && phase_a_low_cmd) [*5]
    |-> gate_low_on[0]) else $error("phase a low gate missing");
  a_int_clear: assert property ($fell(interrupt_out) |-> sel_age < 5'h10)
    else $error("interrupt dropped without a frame");
  a_sdo_rise: assert property ($changed(spi_sdo) && $past(spi_sdo_oe) && spi_sdo_oe
    |-> rise_age >= 4'h2 && rise_age <= 4'h5) else $error("data out moved off a rising clock");
endmodule // predriver_logic_chk
bind predriver_logic predriver_logic_chk u_chk (.clk_sys, .srst, .spi_cs_n, .spi_sclk,
  .spi_sdo, .spi_sdo_oe, .drive_enable_a, .drive_enable_b, .phase_a_low_cmd, .gate_high_on,
  .gate_low_on, .overcurrent_in, .overcurrent_flag_out, .interrupt_out);

// *** dv/spi_host.sv ***
/* Host serial master model.
   Assumes clk is the system clock; a serial half period is four of its cycles. */
`timescale 1ns/1ps
module spi_host (
  // Clock
  input  wire clk,
  // Serial link
  output reg  cs_n,
  output reg  sclk,
  output reg  sdi,
  input  wire sdo
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
  end
  // With sel low the clock toggles while deselected, which the device must ignore.
  task xfer(input [7:0] tx, input integer nbits, input sel, output [7:0] rx);
    integer i;
    begin
      rx = 8'h00;
      @(posedge clk);
      cs_n <= !sel;
      repeat (4) @(posedge clk);
      for (i = 0; i < nbits; i = i + 1) begin
        sdi <= tx[7-i];
        sclk <= 1'b1;
        repeat (4) @(posedge clk);
        sclk <= 1'b0;
        rx = {rx[6:0], sdo};
        repeat (4) @(posedge clk);
      end
      sdi <= 1'b0;
      cs_n <= 1'b1;
      repeat (4) @(posedge clk);
    end
  endtask
endmodule // spi_host

// *** dv/predriver_logic_tb.sv ***
/* Self-checking bench for predriver_logic.
   Assumes spi_host drives the serial link; ce is held high. */
`timescale 1ns/1ps
module predriver_logic_tb;
  reg        clk_sys, srst, overcurrent_in;
  reg  [2:0] high_n, low;
  reg  [1:0] en;
  reg  [7:0] fault_in, rx;
  wire       cs_n, sclk, sdi, sdo, sdo_oe, int_out, ovc_out;
  // A released data line shows the inverse of its last value, so a stray sample shows up.
  wire       host_sdo = sdo_oe ? sdo : ~sdo;
  wire [2:0] gh, gl;
  integer    num_errors, checks_done, i;
  integer    cycles = 0;
  spi_host host (.clk(clk_sys), .cs_n(cs_n), .sclk(sclk), .sdi(sdi), .sdo(host_sdo));
  predriver_logic dut (.clk_sys(clk_sys), .srst(srst), .ce(1'b1), .spi_cs_n(cs_n),
    .spi_sclk(sclk), .spi_sdi(sdi), .spi_sdo(sdo), .spi_sdo_oe(sdo_oe),
    .phase_a_high_cmd_n(high_n[0]), .phase_a_low_cmd(low[0]), .phase_b_high_cmd_n(high_n[1]),
    .phase_b_low_cmd(low[1]), .phase_c_high_cmd_n(high_n[2]), .phase_c_low_cmd(low[2]),
    .drive_enable_a(en[0]), .drive_enable_b(en[1]), .gate_high_on(gh), .gate_low_on(gl),
    .fault_in(fault_in), .overcurrent_in(overcurrent_in), .interrupt_out(int_out),
    .overcurrent_flag_out(ovc_out));
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  task chk(input [7:0] got, input [7:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task results;
    begin
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  task pulse(input [7:0] f);
    begin
      fault_in <= f;
      repeat (6) @(posedge clk_sys);
      fault_in <= 8'h00;
      repeat (6) @(posedge clk_sys);
    end
  endtask
  task frame(input [7:0] tx, input integer n, input sel);
    begin
      host.xfer(tx, n, sel, rx);
      repeat (8) @(posedge clk_sys);
    end
  endtask
  task t_reset;
    begin
      repeat (4) @(posedge clk_sys);
      chk({7'h0, sdo_oe}, 8'h00);
      chk({gh, gl, int_out, ovc_out}, 8'h00);
      $display("t_reset done");
    end
  endtask
  task t_gates;
    begin
      for (i = 0; i < 68; i = i + 1) begin
        high_n <= i[2:0];
        low <= i[5:3];
        en <= (i < 64) ? 2'b11 : i[1:0];
        repeat (6) @(posedge clk_sys);
        chk({5'h0, gh}, (en == 2'b11) ? {5'h0, ~high_n} : 8'h00);
        chk({5'h0, gl}, (en == 2'b11) ? {5'h0, low} : 8'h00);
      end
      high_n <= 3'h7;
      low <= 3'h0;
      $display("t_gates done");
    end
  endtask
  task t_ovc;
    begin
      overcurrent_in <= 1'b1;
      repeat (6) @(posedge clk_sys);
      chk({7'h0, ovc_out}, 8'h01);
      overcurrent_in <= 1'b0;
      repeat (6) @(posedge clk_sys);
      chk({7'h0, ovc_out}, 8'h00);
      $display("t_ovc done");
    end
  endtask
  task t_int;
    begin
      pulse(8'h01);
      repeat (20) @(posedge clk_sys);
      chk({7'h0, int_out}, 8'h01);
      frame(8'h00, 4, 1'b1);
      frame(8'h00, 8, 1'b0);
      chk({7'h0, int_out}, 8'h01);
      frame(8'h00, 8, 1'b1);
      chk({7'h0, int_out}, 8'h00);
      frame(8'h21, 8, 1'b1);
      frame(8'h41, 8, 1'b1);
      pulse(8'h01);
      pulse(8'h10);
      chk({7'h0, int_out}, 8'h00);
      pulse(8'h20);
      chk({7'h0, int_out}, 8'h01);
      frame(8'h60, 8, 1'b1);
      chk(rx, 8'h31);
      frame(8'h00, 8, 1'b1);
      chk({7'h0, int_out}, 8'h00);
      frame(8'h60, 8, 1'b1);
      chk(rx, 8'h00);
      $display("t_int done");
    end
  endtask
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors = num_errors + 1;
      results;
    end
  end
  initial begin
    srst = 1'b1;
    high_n = 3'h7;
    low = 3'h0;
    en = 2'b11;
    fault_in = 8'h00;
    overcurrent_in = 1'b0;
    num_errors = 0;
    checks_done = 0;
    repeat (16) @(posedge clk_sys);
    srst <= 1'b0;
    t_reset;
    t_gates;
    t_ovc;
    t_int;
    results;
  end
endmodule // predriver_logic_tb
